// >>> core/pcs_cmd_status.sv
// Purpose: Configuration command and status registers of one PCI
//          function, with the enable gating that they steer.
// Assumes: Configuration requests and bus events come from logic on
//          core_clk; only the shared PERR wire comes from outside.
// Notes:   One request in flight; answered one cycle after it is taken.
//
// Contract
// - Command bits 15..10 read zero
// - Fast back-to-back enable reads zero, never used
// - SERR driver enabled by system error enable
// - Stepping control fixed at zero
// - PERR driven on parity errors only if enabled
// - Palette snoop enable reads zero
// - Invalidate enable picks MWI, else memory write
// - Special cycle enable zero, special cycles ignored
// - Initiate cycles only while initiator enabled
// - Claim memory cycles only while memory enabled
// - I/O enable zero, no I/O response
// - Command at offset 4 resets to zero
// - Address or data parity error sets detected flag
// - System error signalled while enabled sets flag
// - Own cycle master abort sets flag
// - Own cycle target abort sets flag
// - Target abort issued by us sets flag
// - Device select timing reads 01, medium
// - PERR while mastering and enabled sets flag
// - Back-to-back, USER_FEATURE_SUPPORT, fast clock bits read zero
// - Capability list bit reads one
// - Status bits 3..0 read zero
// - Registers answer only function two accesses
`include "pcs_map.svh"
`timescale 1ns/1ns
`default_nettype none

module pcs_cmd_status
(
  input  wire logic               core_clk,
  input  wire logic               rst,
  // Configuration access
  input  wire logic               cfg_req,
  input  wire logic               cfg_write,
  input  wire logic [2:0]         cfg_func,
  input  wire logic [7:0]         cfg_addr,
  input  wire pcs_pkg::pcs_be_t   cfg_be,
  input  wire pcs_pkg::pcs_word_t cfg_wdata,
  output var  pcs_pkg::pcs_word_t cfg_rdata_reg,
  output var  logic               cfg_ack_reg,
  // Bus events from the interface logic
  input  wire logic               addr_parity_err,
  input  wire logic               data_parity_err,
  input  wire logic               master_data_phase,
  input  wire logic               master_abort_evt,
  input  wire logic               target_abort_rcvd_evt,
  input  wire logic               target_abort_sig_evt,
  // Shared parity error wire, active low
  input  wire logic               perr_bus_n,
  output var  logic               perr_out_n_reg,
  output var  logic               perr_oe_n_reg,
  output var  logic               serr_out_n_reg,
  output var  logic               serr_oe_n_reg,
  // Initiator side
  input  wire logic               initiator_req,
  input  wire logic               initiator_wants_mwi,
  output var  logic               initiator_go_reg,
  output var  pcs_pkg::pcs_buscmd_t initiator_cmd_reg,
  output var  logic               back_to_back_gen_reg,
  output var  logic               stepping_reg,
  // Target side
  input  wire logic               memory_hit,
  input  wire logic               io_hit,
  input  wire logic               special_cycle_hit,
  output var  logic               memory_claim_reg,
  output var  logic               io_claim_reg,
  output var  logic               special_claim_reg,
  output var  logic [1:0]         devsel_timing_reg
);

  import pcs_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // Decode

  // Both registers sit in the same dword; low address bits are ignored, byte enables select lanes
  function automatic logic hits_dword(input logic [7:0] addr,
                                      input logic [7:0] offset);
    hits_dword = (addr[7:2] == offset[7:2]);
  endfunction

  pcs_cfg_state_t cfg_state_reg;
  pcs_cfg_state_t cfg_state_next;
  logic           cfg_take;
  logic           cmd_write;
  logic           stat_write;
  pcs_half_t      cmd_reg;
  pcs_half_t      cmd_next;
  pcs_half_t      stat_view;
  pcs_half_t      stat_clear_bits;

  assign cfg_take = cfg_req
                    && (cfg_func == `PCS_FUNC_NUM)
                    && (cfg_state_reg == pcs_cfg_idle);

  always_comb
  begin
    cmd_write  = 1'b0;
    stat_write = 1'b0;
    if (cfg_take && cfg_write && hits_dword(cfg_addr, `PCS_CMD_OFFSET))
    begin
      cmd_write  = 1'b1;
    end
    if (cfg_take && cfg_write && hits_dword(cfg_addr, `PCS_STAT_OFFSET))
    begin
      stat_write = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Access sequencer

  always_comb
  begin
    cfg_state_next = cfg_state_reg;
    case (cfg_state_reg)
      pcs_cfg_idle:
      begin
        if (cfg_take)
          cfg_state_next = pcs_cfg_answer;
      end
      pcs_cfg_answer:
      begin
        cfg_state_next = pcs_cfg_idle;
      end
      default:
      begin
        cfg_state_next = pcs_cfg_idle;
      end
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
      cfg_state_reg <= pcs_cfg_idle;
    else
      cfg_state_reg <= cfg_state_next;
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
      cfg_ack_reg <= 1'b0;
    else
      cfg_ack_reg <= cfg_take;
  end

  // Unmapped dwords of this function read as zero
  always_ff @(posedge core_clk)
  begin
    if (rst)
      cfg_rdata_reg <= 32'h0000_0000;
    else if (cfg_take && !cfg_write)
    begin
      if (hits_dword(cfg_addr, `PCS_CMD_OFFSET))
        cfg_rdata_reg <= {stat_view, cmd_reg};
      else
        cfg_rdata_reg <= 32'h0000_0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Command register

  // Only bits 8, 6, 4, 2 and 1 store; all else stays zero
  always_comb
  begin
    cmd_next = cmd_reg;
    if (cmd_write)
    begin
      if (cfg_be[0])
        cmd_next[7:0] = cfg_wdata[7:0];
      if (cfg_be[1])
        cmd_next[15:8] = cfg_wdata[15:8];
    end
    cmd_next = cmd_next & `PCS_CMD_WMASK;
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
      cmd_reg <= `PCS_CMD_RESET;
    else
      cmd_reg <= cmd_next;
  end

  ////////////////////////////////////////////////////////////////////////
  // Shared PERR wire synchroniser

  logic perr_meta_n;
  logic perr_sync_n;

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      perr_meta_n <= 1'b1;
      perr_sync_n <= 1'b1;
    end
    else
    begin
      perr_meta_n <= perr_bus_n;
      perr_sync_n <= perr_meta_n;
    end
  end

  // Delay the master flag to line up with the synchronised wire
  logic [1:0] master_phase_dly;

  always_ff @(posedge core_clk)
  begin
    if (rst)
      master_phase_dly <= 2'h0;
    else
      master_phase_dly <= {master_phase_dly[0], master_data_phase};
  end

  ////////////////////////////////////////////////////////////////////////
  // Error pin drivers

  logic serr_fire;
  logic perr_fire;

  assign serr_fire = addr_parity_err && cmd_reg[`PCS_CMD_SERR];
  assign perr_fire = data_parity_err && cmd_reg[`PCS_CMD_PERR];

  // Open drain: drive low for one cycle, float otherwise
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      serr_out_n_reg <= 1'b1;
      serr_oe_n_reg  <= 1'b1;
    end
    else
    begin
      serr_out_n_reg <= !serr_fire;
      serr_oe_n_reg  <= !serr_fire;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      perr_out_n_reg <= 1'b1;
      perr_oe_n_reg  <= 1'b1;
    end
    else
    begin
      perr_out_n_reg <= !perr_fire;
      perr_oe_n_reg  <= !perr_fire;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Sticky status flags

  // Flag order: master parity, sig target abort, rcvd target abort,
  // rcvd master abort, sig system error, detected parity
  localparam int FLAG_POS [`PCS_NUM_FLAGS] = '{
    `PCS_ST_MDPAR, `PCS_ST_STA, `PCS_ST_RTA,
    `PCS_ST_RMA,   `PCS_ST_SSE, `PCS_ST_DPE
  };

  logic [`PCS_NUM_FLAGS-1:0] flag_set;
  logic [`PCS_NUM_FLAGS-1:0] flag_clear;
  logic [`PCS_NUM_FLAGS-1:0] flag_q;
  logic                      mdpar_event;

  // Own detection while mastering, or any agent's PERR seen late
  assign mdpar_event = cmd_reg[`PCS_CMD_PERR]
                       && ((data_parity_err && master_data_phase)
                           || (!perr_sync_n && master_phase_dly[1]));

  assign flag_set[0] = mdpar_event;
  assign flag_set[1] = target_abort_sig_evt;
  assign flag_set[2] = target_abort_rcvd_evt;
  assign flag_set[3] = master_abort_evt;
  assign flag_set[4] = serr_fire;
  assign flag_set[5] = addr_parity_err || data_parity_err;

  always_comb
  begin
    stat_clear_bits = 16'h0000;
    if (stat_write)
    begin
      if (cfg_be[2])
        stat_clear_bits[7:0] = cfg_wdata[23:16];
      if (cfg_be[3])
        stat_clear_bits[15:8] = cfg_wdata[31:24];
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < `PCS_NUM_FLAGS; gi++)
    begin : g_flag
      assign flag_clear[gi] = stat_clear_bits[FLAG_POS[gi]];
      pcs_sticky_flag u_flag
      (
        .core_clk    (core_clk),
        .rst         (rst),
        .set_pulse   (flag_set[gi]),
        .clear_pulse (flag_clear[gi]),
        .flag_reg    (flag_q[gi])
      );
    end
  endgenerate

  // Fixed bits come from the reset pattern; zero elsewhere
  always_comb
  begin
    stat_view = `PCS_STAT_RESET;
    for (int i = 0; i < `PCS_NUM_FLAGS; i++)
    begin
      stat_view[FLAG_POS[i]] = flag_q[i];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Enable gating toward the bus logic

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      initiator_go_reg  <= 1'b0;
      initiator_cmd_reg <= `PCS_BUSCMD_MEMWR;
    end
    else
    begin
      initiator_go_reg <= initiator_req && cmd_reg[`PCS_CMD_MASTER];
      if (initiator_wants_mwi && cmd_reg[`PCS_CMD_MWI])
        initiator_cmd_reg <= `PCS_BUSCMD_MWI;
      else
        initiator_cmd_reg <= `PCS_BUSCMD_MEMWR;
    end
  end

  // The hardwired-zero enables still gate, so a future change of mask
  // cannot silently open a path the block does not support.
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      memory_claim_reg  <= 1'b0;
      io_claim_reg      <= 1'b0;
      special_claim_reg <= 1'b0;
    end
    else
    begin
      memory_claim_reg  <= memory_hit && cmd_reg[`PCS_CMD_MEM];
      io_claim_reg      <= io_hit && cmd_reg[`PCS_CMD_IO];
      special_claim_reg <= special_cycle_hit
                           && cmd_reg[`PCS_CMD_SPECIAL];
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      back_to_back_gen_reg <= 1'b0;
      stepping_reg         <= 1'b0;
      devsel_timing_reg    <= `PCS_DEVSEL_MEDIUM;
    end
    else
    begin
      back_to_back_gen_reg <= cmd_reg[`PCS_CMD_B2B];
      stepping_reg         <= cmd_reg[`PCS_CMD_STEP];
      devsel_timing_reg    <= stat_view[`PCS_ST_DEVSEL_HI:
                                        `PCS_ST_DEVSEL_LO];
    end
  end

endmodule

`default_nettype wire

// >>> core/pcs_map.svh
// Purpose: Offsets, field positions, reset values and codes of the
//          configuration command and status registers.
// Assumes: Byte offsets within the function's configuration space.
// Notes:   Definitions only.
`ifndef PCS_MAP_SVH
`define PCS_MAP_SVH

// Function number that owns these registers
`define PCS_FUNC_NUM        3'h2

// Register offsets (bytes); both share one configuration dword
`define PCS_CMD_OFFSET      8'h04
`define PCS_STAT_OFFSET     8'h06

// Reset values
`define PCS_CMD_RESET       16'h0000
`define PCS_STAT_RESET      16'h0210

// Writable command bits: 8, 6, 4, 2, 1
`define PCS_CMD_WMASK       16'h0156

// Command field positions
`define PCS_CMD_IO          0
`define PCS_CMD_MEM         1
`define PCS_CMD_MASTER      2
`define PCS_CMD_SPECIAL     3
`define PCS_CMD_MWI         4
`define PCS_CMD_PALETTE     5
`define PCS_CMD_PERR        6
`define PCS_CMD_STEP        7
`define PCS_CMD_SERR        8
`define PCS_CMD_B2B         9

// Status field positions
`define PCS_ST_CAPABILITY_CHAIN_PRESENT      4
`define PCS_ST_FASTCLK      5
`define PCS_ST_UDF          6
`define PCS_ST_B2B_CAP      7
`define PCS_ST_MDPAR        8
`define PCS_ST_DEVSEL_LO    9
`define PCS_ST_DEVSEL_HI    10
`define PCS_ST_STA          11
`define PCS_ST_RTA          12
`define PCS_ST_RMA          13
`define PCS_ST_SSE          14
`define PCS_ST_DPE          15

// Fixed field values
`define PCS_DEVSEL_MEDIUM   2'h1
`define PCS_BUSCMD_MEMWR    4'h7
`define PCS_BUSCMD_MWI      4'hF

// Number of sticky status flags
`define PCS_NUM_FLAGS       6

`endif

// >>> core/pcs_pkg.sv
// Purpose: Types shared by the command and status register block.
// Assumes: Nothing beyond the map header.
// Notes:   Constants live in pcs_map.svh.
`default_nettype none

package pcs_pkg;

  typedef logic [31:0] pcs_word_t;
  typedef logic [15:0] pcs_half_t;
  typedef logic [3:0]  pcs_be_t;
  typedef logic [3:0]  pcs_buscmd_t;

  typedef enum logic {
    pcs_cfg_idle,
    pcs_cfg_answer
  } pcs_cfg_state_t;

endpackage

`default_nettype wire

// >>> core/pcs_sticky_flag.sv
// Purpose: One read/clear status flag.
// Assumes: set and clear are one-cycle pulses on core_clk.
// Notes:   A set in the clearing cycle wins, so no event is lost.
`timescale 1ns/1ns
`default_nettype none

module pcs_sticky_flag
(
  input  wire logic core_clk,
  input  wire logic rst,
  input  wire logic set_pulse,
  input  wire logic clear_pulse,
  output var  logic flag_reg
);

  always_ff @(posedge core_clk)
  begin
    if (rst)
      flag_reg <= 1'b0;
    else if (set_pulse)
      flag_reg <= 1'b1;
    else if (clear_pulse)
      flag_reg <= 1'b0;
  end

endmodule

`default_nettype wire

// >>> testbench/pcs_bus_agent.sv
// Purpose: Other agents on the shared parity error wire.
// Assumes: The wire has a pull-up.
// Notes:   The bench raises agent_perr to act as another agent.
`timescale 1ns/1ns
`default_nettype none
module pcs_bus_agent
(
  input  wire logic agent_perr,
  input  wire logic perr_out_n_reg,
  input  wire logic perr_oe_n_reg,
  output wire logic perr_bus_n
);
  // Wired low by any driver; the pull-up restores high on release
  assign perr_bus_n = !(agent_perr || (!perr_oe_n_reg && !perr_out_n_reg));
endmodule
`default_nettype wire

// >>> testbench/pcs_cmd_status_props.sv
// Purpose: Port assertions for the command and status block.
// Assumes: One clock domain, synchronous reset.
// Notes:   Read checks look only at the command and status dword.
`include "pcs_map.svh"
`timescale 1ns/1ns
`default_nettype none
module pcs_cmd_status_props
(
  input wire logic               core_clk,
  input wire logic               rst,
  input wire logic               cfg_req,
  input wire logic               cfg_write,
  input wire logic [2:0]         cfg_func,
  input wire logic [7:0]         cfg_addr,
  input wire pcs_pkg::pcs_word_t cfg_rdata_reg,
  input wire logic               cfg_ack_reg,
  input wire logic               addr_parity_err,
  input wire logic               data_parity_err,
  input wire logic               initiator_req,
  input wire logic               initiator_wants_mwi,
  input wire logic               memory_hit,
  input wire logic               perr_out_n_reg,
  input wire logic               perr_oe_n_reg,
  input wire logic               serr_out_n_reg,
  input wire logic               serr_oe_n_reg,
  input wire logic               initiator_go_reg,
  input wire pcs_pkg::pcs_buscmd_t initiator_cmd_reg,
  input wire logic               back_to_back_gen_reg,
  input wire logic               stepping_reg,
  input wire logic               memory_claim_reg,
  input wire logic               io_claim_reg,
  input wire logic               special_claim_reg,
  input wire logic [1:0]         devsel_timing_reg
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  AST_ACK: assert property (cfg_req && cfg_func == `PCS_FUNC_NUM
    && !cfg_ack_reg |=> cfg_ack_reg) else $error("missing ack");
  AST_NOACK: assert property (!(cfg_req && cfg_func == `PCS_FUNC_NUM)
    |=> !cfg_ack_reg) else $error("unexpected ack");
  AST_READ: assert property (cfg_ack_reg && !$past(cfg_write)
    && $past(cfg_addr) == `PCS_CMD_OFFSET |->
    (cfg_rdata_reg & 32'h04EF_FEA9) == 32'h0 &&
    (cfg_rdata_reg[31:16] & 16'h0210) == 16'h0210)
    else $error("fixed bits wrong");
  AST_FIXED: assert property (!back_to_back_gen_reg && !stepping_reg
    && !io_claim_reg && !special_claim_reg
    && devsel_timing_reg == `PCS_DEVSEL_MEDIUM) else $error("fixed output");
  AST_GO: assert property (initiator_go_reg |-> $past(initiator_req))
    else $error("go without request");
  AST_MWI: assert property (initiator_cmd_reg != `PCS_BUSCMD_MEMWR
    |-> initiator_cmd_reg == `PCS_BUSCMD_MWI && $past(initiator_wants_mwi))
    else $error("bad bus command");
  AST_MEM: assert property (memory_claim_reg |-> $past(memory_hit))
    else $error("claim without hit");
  AST_SERR: assert property (!serr_oe_n_reg |-> !serr_out_n_reg
    && $past(addr_parity_err)) else $error("serr drive");
  AST_PERR: assert property (!perr_oe_n_reg |-> !perr_out_n_reg
    && $past(data_parity_err)) else $error("perr drive");
  COV_WR: cover property (cfg_ack_reg && $past(cfg_write));
  COV_SERR: cover property (!serr_oe_n_reg);
  COV_PERR: cover property (!perr_oe_n_reg);
  COV_GO: cover property (initiator_go_reg);
endmodule
bind pcs_cmd_status pcs_cmd_status_props u_props (.*);
`default_nettype wire

// >>> testbench/test_pci_config_command_status.sv
// Purpose: Self-checking bench for the command and status block.
// Assumes: Inputs change 1 ns after the rising edge.
// Notes:   Events are one-cycle pulses from the evt vector.
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin n_mismatch++; \
  $display("CHECK FAILED %0t value mismatch", $time); end end
module test_pci_config_command_status;
  import pcs_pkg::*;
  logic core_clk, rst, cfg_req, cfg_write, mdp, agent_perr, perr_n;
  logic ireq, imwi, mhit, iohit, shit, ack, ooe, oout, goo, mc, ioc, sc;
  logic seo, seout, b2b, stp;
  logic [1:0] dsel;
  logic [2:0] cfg_func;
  logic [7:0] cfg_addr;
  logic [4:0] evt;
  pcs_be_t    cfg_be;
  pcs_word_t  cfg_wdata, rdata, q;
  pcs_buscmd_t icmd;
  int n_mismatch = 0;
  int n_compared = 0;
  pcs_cmd_status dut (.core_clk(core_clk), .rst(rst), .cfg_req(cfg_req),
    .cfg_write(cfg_write), .cfg_func(cfg_func), .cfg_addr(cfg_addr),
    .cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_rdata_reg(rdata),
    .cfg_ack_reg(ack), .addr_parity_err(evt[4]), .data_parity_err(evt[3]),
    .master_data_phase(mdp), .master_abort_evt(evt[2]),
    .target_abort_rcvd_evt(evt[1]), .target_abort_sig_evt(evt[0]),
    .perr_bus_n(perr_n), .perr_out_n_reg(oout), .perr_oe_n_reg(ooe),
    .serr_out_n_reg(seout), .serr_oe_n_reg(seo), .initiator_req(ireq),
    .initiator_wants_mwi(imwi), .initiator_go_reg(goo),
    .initiator_cmd_reg(icmd), .back_to_back_gen_reg(b2b),
    .stepping_reg(stp), .memory_hit(mhit), .io_hit(iohit),
    .special_cycle_hit(shit), .memory_claim_reg(mc), .io_claim_reg(ioc),
    .special_claim_reg(sc), .devsel_timing_reg(dsel));
  pcs_bus_agent agent (.agent_perr(agent_perr), .perr_out_n_reg(oout),
    .perr_oe_n_reg(ooe), .perr_bus_n(perr_n));
  initial
  begin
    core_clk = 0;
    forever #50 core_clk = ~core_clk;
  end
  //////////////////////////////////////////////////////////////////////
  task tick;
    @(posedge core_clk);
    #1;
  endtask
  task summarize;
    $display("Compared %0d, mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // One request, then a gap cycle so requests never run back to back
  task cfg(input logic w, input logic [2:0] f, input logic [7:0] a,
           input pcs_be_t be, input pcs_word_t d);
    int i;
    {cfg_req, cfg_write, cfg_func, cfg_addr, cfg_be, cfg_wdata} =
      {1'b1, w, f, a, be, d};
    tick;
    cfg_req = 0;
    for (i = 0; i < 3 && ack !== 1'b1; i++)
      tick;
    if (ack !== 1'b1)
    begin
      n_mismatch++;
      summarize;
    end
    q = rdata;
    tick;
  endtask
  task wr(input pcs_be_t be, input pcs_word_t d);
    cfg(1'b1, 3'h2, 8'h04, be, d);
  endtask
  task rd;
    cfg(1'b0, 3'h2, 8'h04, 4'hF, 32'h0);
  endtask
  task pulse(input logic [4:0] e);
    evt = e;
    tick;
    evt = 5'h00;
  endtask
  //////////////////////////////////////////////////////////////////////
  task t_reset_and_fixed;
    rd;
    `CHK(q, 32'h0210_0000)
    `CHK(icmd, 4'h7)
    wr(4'hF, 32'hFFFF_FFFF);
    `CHK({b2b, stp, dsel}, 4'h1)
    rd;
    `CHK(q, 32'h0210_0156)
  endtask
  task t_enables;
    {ireq, imwi, mhit, iohit, shit} = 5'h1F;
    tick;
    `CHK({goo, icmd, mc, ioc, sc}, 8'hFC)
    wr(4'h3, 32'h0);
    `CHK({goo, icmd, mc}, 6'h0E)
    {ireq, imwi, mhit, iohit, shit} = 5'h00;
  endtask
  task t_system_error;
    wr(4'h3, 32'h0000_0100);
    pulse(5'h10);
    `CHK({seo, seout}, 2'h0)
    tick;
    `CHK(seo, 1'b1)
    rd;
    `CHK(q, 32'hC210_0100)
    wr(4'hC, 32'hFFFF_0000);
    rd;
    `CHK(q, 32'h0210_0100)
    wr(4'h3, 32'h0);
    pulse(5'h10);
    `CHK(seo, 1'b1)
    rd;
    `CHK(q, 32'h8210_0000)
    wr(4'hC, 32'hFFFF_0000);
  endtask
  task t_parity;
    wr(4'h3, 32'h0000_0040);
    mdp = 1;
    pulse(5'h08);
    `CHK({ooe, oout}, 2'h0)
    // Let our own PERR echo pass the synchroniser before clearing
    repeat (2) tick;
    rd;
    `CHK(q, 32'h8310_0040)
    wr(4'hC, 32'hFFFF_0000);
    mdp = 0;
    agent_perr = 1;
    tick;
    agent_perr = 0;
    repeat (3) tick;
    rd;
    `CHK(q, 32'h0210_0040)
    mdp = 1;
    agent_perr = 1;
    tick;
    agent_perr = 0;
    repeat (3) tick;
    rd;
    `CHK(q, 32'h0310_0040)
    wr(4'hF, 32'hFFFF_0000);
    pulse(5'h08);
    `CHK(ooe, 1'b1)
    rd;
    `CHK(q, 32'h8210_0000)
    mdp = 0;
    wr(4'hC, 32'hFFFF_0000);
  endtask
  task t_aborts;
    pulse(5'h07);
    rd;
    `CHK(q, 32'h3A10_0000)
    wr(4'hC, 32'h1000_0000);
    rd;
    `CHK(q, 32'h2A10_0000)
    // Clear and a new event on the same edge: the event must survive
    fork
      wr(4'hC, 32'h2800_0000);
      pulse(5'h04);
    join
    rd;
    `CHK(q, 32'h2210_0000)
  endtask
  task t_function_select;
    {cfg_req, cfg_func, cfg_addr} = {1'b1, 3'h1, 8'h04};
    tick;
    cfg_req = 0;
    `CHK(ack, 1'b0)
    tick;
    cfg(1'b0, 3'h2, 8'h08, 4'hF, 32'h0);
    `CHK(q, 32'h0)
  endtask
  initial
  begin
    {rst, cfg_req, cfg_write, cfg_func, cfg_addr, cfg_be} = 18'h20000;
    {cfg_wdata, evt, mdp, agent_perr} = 39'h0;
    {ireq, imwi, mhit, iohit, shit} = 5'h00;
    repeat (5) tick;
    rst = 0;
    t_reset_and_fixed;
    t_enables;
    t_system_error;
    t_parity;
    t_aborts;
    t_function_select;
    summarize;
  end
endmodule
`default_nettype wire
